// ### shared/autoneg_pkg.sv
/*
  Constants for the negotiation configuration and control block: register
  offsets, field positions, reset values and timer lengths.
  Assumes a 50 MHz system clock and 32-bit AHB-Lite word access.
*/
package autoneg_pkg;

  localparam int unsigned CLK_HZ = 50_000_000;

  // register word indices (byte offset divided by four)
  localparam logic [7:0] IDX_CONTROL  = 8'h00;
  localparam logic [7:0] IDX_STATUS   = 8'h01;
  localparam logic [7:0] IDX_ADVERT   = 8'h04;
  localparam logic [7:0] IDX_PARTNER  = 8'h05;
  localparam logic [7:0] IDX_EXPAND   = 8'h06;
  localparam logic [7:0] IDX_LINKSTS  = 8'h10;

  // control fields
  localparam int CTL_SPEED   = 13;
  localparam int CTL_NEG_EN  = 12;
  localparam int CTL_RESTART = 9;
  localparam int CTL_DUPLEX  = 8;

  // ability field positions in advertisement / partner words
  localparam int AB_10H  = 5;
  localparam int AB_10F  = 6;
  localparam int AB_100H = 7;
  localparam int AB_100F = 8;
  localparam int AB_RF   = 13;
  localparam int AB_NP   = 15;

  localparam logic [4:0]  SELECTOR_8023    = 5'h01;
  localparam logic [15:0] ADVERT_BASE      = 16'h0001;
  localparam logic [15:0] PD_PARTNER_100   = 16'h0081;
  localparam logic [15:0] PD_PARTNER_10    = 16'h0021;
  // 100tx full/half, 10 full/half, no T4, preamble suppression, extended
  localparam logic [15:0] STATUS_FIXED     = 16'h7849;

  // link status fields
  localparam int LS_LINK   = 0;
  localparam int LS_SPEED10 = 1;
  localparam int LS_DUPLEX = 2;
  localparam int LS_NEG_DONE = 4;

  // timers
  localparam int unsigned BREAK_LINK_MS  = 1500;
  localparam int unsigned BREAK_LINK_CYC = BREAK_LINK_MS * (CLK_HZ / 1000);
  localparam int unsigned BURST_US       = 16000;
  localparam int unsigned BURST_CYC      = BURST_US * (CLK_HZ / 1_000_000);

endpackage : autoneg_pkg

// ### core/autoneg_ctrl.sv
/*
  Auto-negotiation configuration and control of a 10/100 transceiver, with
  an AHB-Lite register slave, strap sampling, ability exchange hand-off to
  the line side and parallel detection.
  Assumes the line side delivers decoded partner code words and link status
  levels synchronous to mclk_in, and sends our word when burst_send_out pulses.
*/
// What this block does
// - negotiate strap low forces mode from ability straps
// - negotiate strap high selects advertised ability set
// - straps load advertisement bits 8:5 at reset
// - control register write overrides strap setup anytime
// - advertisement word sent in bursts while negotiating
// - priority 100 full, 100 half, 10 full, 10 half
// - control register enables, disables, restarts negotiation
// - negotiation off: speed and duplex bits set mode
// - negotiation on: speed and duplex bits ignored
// - link status register reports resolved speed
// - status shows fixed abilities, no T4
// - status shows complete, remote fault, link, preamble
// - advertise strap-selected abilities by default; software may clear
// - partner base and next pages stored in register
// - parallel detect loads partner word 0081h or 0021h
// - expansion shows fault, next page, page, able
// - both receivers' links drive parallel detection
// - parallel detect sets bit 5 or 7, selector
// - parallel detect completion leaves partner-able zero
// - both links good at once sets fault
// - restart bit 9 starts new negotiation
// - renegotiation silences line for break-link time
// - lost link resumes negotiation automatically
`timescale 1ns/1ps
module autoneg_ctrl
  import autoneg_pkg::*;
#(
  parameter int unsigned BREAK_CYCLES = BREAK_LINK_CYC,
  parameter int unsigned BURST_CYCLES = BURST_CYC
) (
  // clock and reset
  input  wire logic        mclk_in,
  input  wire logic        arst_n_in,
  // configuration straps
  input  wire logic        negotiate_strap_in,
  input  wire logic        ability_strap_hi_in,
  input  wire logic        ability_strap_lo_in,
  // ahb-lite slave
  input  wire logic        hsel_in,
  input  wire logic [31:0] haddr_in,
  input  wire logic [1:0]  htrans_in,
  input  wire logic        hwrite_in,
  input  wire logic [2:0]  hsize_in,
  input  wire logic        hready_in,
  input  wire logic [31:0] hwdata_in,
  output logic      [31:0] hrdata_out,
  output logic             hreadyout_out,
  output logic             hresp_out,
  // line side
  input  wire logic        link_10_in,
  input  wire logic        link_100_in,
  input  wire logic        flp_seen_in,
  input  wire logic        page_valid_in,
  input  wire logic [15:0] page_word_in,
  output logic             burst_send_out,
  output logic [15:0]      burst_word_out,
  output logic             line_quiet_out,
  // resolved operating mode
  output logic             speed_100_out,
  output logic             full_duplex_out,
  output logic             link_up_out
);

  typedef enum logic [2:0] {
    ST_FORCED, ST_BREAK, ST_EXCHANGE, ST_UP_NEG, ST_UP_PD
  } neg_state_type;

  neg_state_type state_r;
  logic [15:0] control_r;
  logic [15:0] advert_r;
  logic [15:0] partner_r;
  logic        strap_neg_r;
  logic [1:0]  strap_ab_r;
  logic        straps_taken_r;
  logic        forced_start_r;
  logic        neg_cleared_r;
  logic        pd_fault_r;
  logic        page_rx_r;
  logic        partner_able_r;
  logic        link_lost_r;
  logic [31:0] timer_r;
  logic        restart_req;
  logic        neg_enabled;

  // address phase capture
  logic        dp_valid_r;
  logic        dp_write_r;
  logic [7:0]  dp_index_r;

  always_ff @(posedge mclk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      dp_valid_r <= 1'b0;
      dp_write_r <= 1'b0;
      dp_index_r <= 8'h00;
    end else if (hready_in) begin
      dp_valid_r <= hsel_in && htrans_in[1];
      dp_write_r <= hwrite_in;
      dp_index_r <= haddr_in[9:2];
    end
  end

  wire wr_ctl = dp_valid_r && dp_write_r && dp_index_r == IDX_CONTROL;
  wire wr_adv = dp_valid_r && dp_write_r && dp_index_r == IDX_ADVERT;

  // straps are caught on the first clock after reset release
  always_ff @(posedge mclk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      straps_taken_r <= 1'b0;
      strap_neg_r    <= 1'b0;
      strap_ab_r     <= 2'h0;
    end else if (!straps_taken_r) begin
      straps_taken_r <= 1'b1;
      strap_neg_r    <= negotiate_strap_in;
      strap_ab_r     <= {ability_strap_hi_in, ability_strap_lo_in};
    end
  end

  function automatic logic [3:0] strap_abilities(input logic neg, input logic [1:0] ab);
    logic [3:0] r;   // {100f,100h,10f,10h}
    r = 4'h0;
    if (neg) begin
      unique case (ab)
        2'h0: r = 4'h3;
        2'h1: r = 4'hC;
        2'h2: r = 4'h5;
        2'h3: r = 4'hF;
      endcase
    end else begin
      unique case (ab)
        2'h0: r = 4'h1;
        2'h1: r = 4'h2;
        2'h2: r = 4'h4;
        2'h3: r = 4'h8;
      endcase
    end
    return r;
  endfunction : strap_abilities

  // control register; restart bit self-clears
  always_ff @(posedge mclk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      control_r <= 16'h0000;
    end else if (!straps_taken_r) begin
      control_r <= 16'h0000;
      control_r[CTL_NEG_EN] <= negotiate_strap_in;
      control_r[CTL_SPEED]  <= ability_strap_hi_in;
      control_r[CTL_DUPLEX] <= ability_strap_lo_in;
    end else if (wr_ctl) begin
      control_r <= hwdata_in[15:0] & 16'h3300;
    end else begin
      control_r[CTL_RESTART] <= 1'b0;
    end
  end

  always_ff @(posedge mclk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      advert_r <= ADVERT_BASE;
    end else if (!straps_taken_r) begin
      advert_r <= ADVERT_BASE;
      advert_r[AB_100F:AB_10H] <=
        strap_abilities(negotiate_strap_in,
                        {ability_strap_hi_in, ability_strap_lo_in});
    end else if (wr_adv) begin
      advert_r <= {hwdata_in[15:5], SELECTOR_8023};
    end
  end

  // a forced start needs enable seen low before negotiation takes effect
  always_ff @(posedge mclk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      forced_start_r <= 1'b0;
      neg_cleared_r  <= 1'b0;
    end else if (!straps_taken_r) begin
      forced_start_r <= !negotiate_strap_in;
      neg_cleared_r  <= 1'b0;
    end else if (!control_r[CTL_NEG_EN]) begin
      neg_cleared_r  <= 1'b1;
    end
  end

  assign neg_enabled = straps_taken_r && control_r[CTL_NEG_EN]
                       && (!forced_start_r || neg_cleared_r);
  assign restart_req = control_r[CTL_RESTART];

  // best common ability, one-hot {100f,100h,10f,10h}
  function automatic logic [3:0] resolve(input logic [3:0] a);
    if (a[3])      return 4'h8;
    else if (a[2]) return 4'h4;
    else if (a[1]) return 4'h2;
    else if (a[0]) return 4'h1;
    else           return 4'h0;
  endfunction : resolve

  wire [3:0] common = advert_r[AB_100F:AB_10H] & partner_r[AB_100F:AB_10H];
  wire [3:0] best   = resolve(common);
  wire       one_link = link_10_in ^ link_100_in;

  // negotiation state and timer
  always_ff @(posedge mclk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      state_r        <= ST_FORCED;
      timer_r        <= 32'h0000_0000;
      partner_r      <= 16'h0000;
      pd_fault_r     <= 1'b0;
      page_rx_r      <= 1'b0;
      partner_able_r <= 1'b0;
      burst_send_out <= 1'b0;
      link_lost_r    <= 1'b0;
    end else begin
      burst_send_out <= 1'b0;
      // cleared at the edge that captures the read data, so no set is lost
      if (hready_in && hsel_in && htrans_in[1] && !hwrite_in
          && haddr_in[9:2] == IDX_EXPAND) begin
        pd_fault_r <= 1'b0;
        page_rx_r  <= 1'b0;
      end
      if (!neg_enabled) begin
        state_r <= ST_FORCED;
      end else if (restart_req || state_r == ST_FORCED || link_lost_r) begin
        state_r     <= ST_BREAK;
        timer_r     <= BREAK_CYCLES - 1;
        link_lost_r <= 1'b0;
      end else begin
        unique case (state_r)
          ST_BREAK: begin
            if (timer_r == 32'h0) begin
              state_r        <= ST_EXCHANGE;
              timer_r        <= 32'h0;
              partner_able_r <= 1'b0;
            end else begin
              timer_r <= timer_r - 32'h1;
            end
          end
          ST_EXCHANGE: begin
            if (timer_r == 32'h0) begin
              burst_send_out <= 1'b1;
              timer_r        <= BURST_CYCLES - 1;
            end else begin
              timer_r <= timer_r - 32'h1;
            end
            if (page_valid_in) begin
              partner_r      <= page_word_in;
              page_rx_r      <= 1'b1;
              partner_able_r <= 1'b1;
            end
            if (partner_able_r && best != 4'h0 && (link_10_in || link_100_in)) begin
              state_r <= ST_UP_NEG;
            end else if (!flp_seen_in && !partner_able_r
                         && (link_10_in || link_100_in)) begin
              if (one_link) begin
                partner_r <= link_100_in ? PD_PARTNER_100 : PD_PARTNER_10;
                state_r   <= ST_UP_PD;
              end else begin
                pd_fault_r <= 1'b1;
              end
            end
          end
          ST_UP_NEG, ST_UP_PD: begin
            if (!(link_10_in || link_100_in)) begin
              link_lost_r <= 1'b1;
            end
          end
          default: state_r <= ST_FORCED;
        endcase
      end
    end
  end

  wire neg_done = state_r == ST_UP_NEG || state_r == ST_UP_PD;

  // operating mode
  always_ff @(posedge mclk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      speed_100_out   <= 1'b0;
      full_duplex_out <= 1'b0;
      link_up_out     <= 1'b0;
      line_quiet_out  <= 1'b0;
      burst_word_out  <= ADVERT_BASE;
    end else begin
      burst_word_out <= advert_r;
      line_quiet_out <= neg_enabled && state_r == ST_BREAK;
      if (!neg_enabled) begin
        speed_100_out   <= control_r[CTL_SPEED];
        full_duplex_out <= control_r[CTL_DUPLEX];
        link_up_out     <= control_r[CTL_SPEED] ? link_100_in : link_10_in;
      end else if (state_r == ST_UP_PD) begin
        speed_100_out   <= partner_r[AB_100H];
        full_duplex_out <= 1'b0;
        link_up_out     <= 1'b1;
      end else if (state_r == ST_UP_NEG) begin
        speed_100_out   <= best[3] || best[2];
        full_duplex_out <= best[3] || best[1];
        link_up_out     <= 1'b1;
      end else begin
        link_up_out     <= 1'b0;
      end
    end
  end

  // read mux on the address phase, so hrdata stands through the data phase
  logic [15:0] rd_word;
  always_comb begin
    rd_word = 16'h0000;
    unique case (haddr_in[9:2])
      IDX_CONTROL: rd_word = control_r;
      IDX_STATUS: begin
        rd_word = STATUS_FIXED;
        rd_word[2] = link_up_out;
        rd_word[4] = partner_r[AB_RF] && state_r == ST_UP_NEG;
        rd_word[5] = neg_done;
      end
      IDX_ADVERT:  rd_word = advert_r;
      IDX_PARTNER: rd_word = partner_r;
      IDX_EXPAND:  rd_word = {11'h000, pd_fault_r, partner_r[AB_NP] && partner_able_r,
                              1'b0, page_rx_r, partner_able_r};
      IDX_LINKSTS: rd_word = {11'h000, neg_done, 1'b0, full_duplex_out,
                              !speed_100_out, link_up_out};
      default:     rd_word = 16'h0000;
    endcase
  end

  always_ff @(posedge mclk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      hrdata_out    <= 32'h0000_0000;
      hreadyout_out <= 1'b1;
      hresp_out     <= 1'b0;
    end else begin
      hrdata_out    <= {16'h0000, rd_word};
      hreadyout_out <= 1'b1;
      hresp_out     <= 1'b0;
    end
  end

endmodule : autoneg_ctrl

// ### verif/autoneg_monitor.sv
/* Assertion checker for autoneg_ctrl, bound to its ports below.
   Assumes one AHB-Lite slave whose hreadyout feeds hready_in. */
`timescale 1ns/1ps
module autoneg_monitor
  import autoneg_pkg::*;
#(
  parameter int unsigned BREAK_CYCLES = 20
) (
  // clock, reset, bus
  input wire logic        mclk_in,
  input wire logic        arst_n_in,
  input wire logic        hsel_in,
  input wire logic [31:0] haddr_in,
  input wire logic [1:0]  htrans_in,
  input wire logic        hwrite_in,
  input wire logic        hready_in,
  input wire logic [31:0] hwdata_in,
  input wire logic [31:0] hrdata_out,
  // line and mode
  input wire logic        burst_send_out,
  input wire logic        line_quiet_out,
  input wire logic        speed_100_out,
  input wire logic        full_duplex_out,
  input wire logic        link_up_out
);
  logic        dp_wr_r;
  logic        dp_rd_r;
  logic        spd_r;
  logic        dup_r;
  logic [7:0]  idx_r;
  logic [31:0] quiet_cnt_r;
  logic        ctl_wr;
  assign ctl_wr = dp_wr_r && (idx_r == IDX_CONTROL);
  // forced bits kept until the next control write, as the mode may lag
  always_ff @(posedge mclk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      dp_wr_r <= 1'b0;
      dp_rd_r <= 1'b0;
      idx_r   <= 8'h00;
      spd_r   <= 1'b0;
      dup_r   <= 1'b0;
    end else begin
      dp_wr_r <= hsel_in && hready_in && htrans_in[1] && hwrite_in;
      dp_rd_r <= hsel_in && hready_in && htrans_in[1] && !hwrite_in;
      idx_r   <= haddr_in[9:2];
      if (ctl_wr) begin
        spd_r <= hwdata_in[CTL_SPEED];
        dup_r <= hwdata_in[CTL_DUPLEX];
      end
    end
  end
  always_ff @(posedge mclk_in or negedge arst_n_in) begin
    if (!arst_n_in)
      quiet_cnt_r <= 32'h0;
    else if (line_quiet_out)
      quiet_cnt_r <= quiet_cnt_r + 32'h1;
    else
      quiet_cnt_r <= 32'h0;
  end
  default clocking @(posedge mclk_in);
  endclocking
  default disable iff (!arst_n_in);
  property p_quiet; line_quiet_out |-> !burst_send_out; endproperty
  a_quiet: assert property (p_quiet) else $error("burst while quiet");
  property p_brk;
    $fell(line_quiet_out) |-> quiet_cnt_r >= BREAK_CYCLES && quiet_cnt_r <= BREAK_CYCLES + 1;
  endproperty
  a_brk: assert property (p_brk) else $error("break length wrong");
  property p_resume; $fell(line_quiet_out) |-> ##[0:2] burst_send_out; endproperty
  a_resume: assert property (p_resume) else $error("no burst after break");
  property p_pulse; burst_send_out |=> !burst_send_out; endproperty
  a_pulse: assert property (p_pulse) else $error("burst pulse too long");
  property p_restart;
    ctl_wr && hwdata_in[CTL_NEG_EN] && hwdata_in[CTL_RESTART] |-> ##[1:3] line_quiet_out;
  endproperty
  a_restart: assert property (p_restart) else $error("restart ignored");
  property p_forced;
    ctl_wr && !hwdata_in[CTL_NEG_EN]
      |-> ##[1:4] (speed_100_out == spd_r && full_duplex_out == dup_r);
  endproperty
  a_forced: assert property (p_forced) else $error("forced mode wrong");
  property p_ignore;
    ctl_wr && hwdata_in[CTL_NEG_EN] && !hwdata_in[CTL_RESTART] && link_up_out
      |=> ($stable(speed_100_out) && $stable(full_duplex_out)) [*3];
  endproperty
  a_ignore: assert property (p_ignore) else $error("mode bits not ignored");
  property p_fixed;
    dp_rd_r && idx_r == IDX_STATUS |-> (hrdata_out[15:0] & 16'hF849) == STATUS_FIXED;
  endproperty
  a_fixed: assert property (p_fixed) else $error("status fixed bits");
  property p_linksts;
    dp_rd_r && idx_r == IDX_LINKSTS && link_up_out
      |-> hrdata_out[2:0] == {full_duplex_out, !speed_100_out, 1'b1};
  endproperty
  a_linksts: assert property (p_linksts) else $error("link status wrong");
endmodule : autoneg_monitor

bind autoneg_ctrl autoneg_monitor #(.BREAK_CYCLES(BREAK_CYCLES)) u_monitor (
  .mclk_in(mclk_in), .arst_n_in(arst_n_in), .hsel_in(hsel_in), .haddr_in(haddr_in),
  .htrans_in(htrans_in), .hwrite_in(hwrite_in), .hready_in(hready_in),
  .hwdata_in(hwdata_in), .hrdata_out(hrdata_out), .burst_send_out(burst_send_out),
  .line_quiet_out(line_quiet_out), .speed_100_out(speed_100_out),
  .full_duplex_out(full_duplex_out), .link_up_out(link_up_out)
);

// ### verif/link_partner_model.sv
/* Behavioural remote link partner on the line side.
   Assumes the bench picks its abilities, links and answer delay. */
`timescale 1ns/1ps
module link_partner_model (
  // clock, reset
  input  wire logic        clk_in,
  input  wire logic        arst_n_in,
  // bench controls
  input  wire logic        flp_en_in,
  input  wire logic        l10_en_in,
  input  wire logic        l100_en_in,
  input  wire logic        slow_in,
  input  wire logic [15:0] word_in,
  // device line side
  input  wire logic        burst_in,
  input  wire logic        quiet_in,
  output logic             link_10_out,
  output logic             link_100_out,
  output logic             flp_seen_out,
  output logic             page_valid_out,
  output logic [15:0]      page_word_out
);
  logic [3:0] delay_r;
  // a silenced line drops the partner into link fail
  assign link_10_out  = l10_en_in && !quiet_in;
  assign link_100_out = l100_en_in && !quiet_in;
  assign flp_seen_out = flp_en_in && !quiet_in;
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      delay_r        <= 4'h0;
      page_valid_out <= 1'b0;
      page_word_out  <= 16'h0000;
    end else begin
      page_valid_out <= 1'b0;
      // word is not held between pages
      page_word_out  <= ~page_word_out;
      if (burst_in && flp_en_in)
        delay_r <= slow_in ? 4'h6 : 4'h1;
      else if (delay_r != 4'h0) begin
        delay_r <= delay_r - 4'h1;
        if (delay_r == 4'h1) begin
          page_valid_out <= 1'b1;
          page_word_out  <= word_in;
        end
      end
    end
  end
endmodule : link_partner_model

// ### verif/test_autoneg_ctrl.sv
/* Self-checking bench: AHB-Lite register traffic, straps, link partner.
   Assumes shortened break and burst timers. */
`timescale 1ns/1ps
module test_autoneg_ctrl
  import autoneg_pkg::*;
;
  localparam logic [31:0] ADV [4] = '{32'h61, 32'h181, 32'hA1, 32'h1E1};
  logic        clk = 1'b0;
  logic        arst_n = 1'b0;
  logic [2:0]  straps = 3'b100;
  logic        hsel = 1'b0;
  logic        hwrite = 1'b0;
  logic [1:0]  htrans = 2'b00;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] q = 32'h0;
  logic [31:0] hrdata;
  logic        hrdy, hresp, l10, l100, flp, pv, bsend, quiet, spd, fdx, lup;
  logic [15:0] pword;
  logic [15:0] bword;
  logic [3:0]  pmode = 4'h0;
  int          num_errors = 0;
  int          comparisons = 0;
  always #10 clk = ~clk;
  autoneg_ctrl #(.BREAK_CYCLES(20), .BURST_CYCLES(10)) u_dut (
    .mclk_in(clk), .arst_n_in(arst_n), .negotiate_strap_in(straps[2]),
    .ability_strap_hi_in(straps[1]), .ability_strap_lo_in(straps[0]),
    .hsel_in(hsel), .haddr_in(haddr), .htrans_in(htrans), .hwrite_in(hwrite),
    .hsize_in(3'b010), .hready_in(hrdy), .hwdata_in(hwdata), .hrdata_out(hrdata),
    .hreadyout_out(hrdy), .hresp_out(hresp), .link_10_in(l10), .link_100_in(l100),
    .flp_seen_in(flp), .page_valid_in(pv), .page_word_in(pword),
    .burst_send_out(bsend), .burst_word_out(bword), .line_quiet_out(quiet),
    .speed_100_out(spd), .full_duplex_out(fdx), .link_up_out(lup));
  link_partner_model u_partner (
    .clk_in(clk), .arst_n_in(arst_n), .flp_en_in(pmode[3]), .l100_en_in(pmode[2]),
    .l10_en_in(pmode[1]), .slow_in(pmode[0]), .word_in(16'h00E1), .burst_in(bsend),
    .quiet_in(quiet), .link_10_out(l10), .link_100_out(l100), .flp_seen_out(flp),
    .page_valid_out(pv), .page_word_out(pword));
  task automatic results();
    $display("errors %0d comparisons %0d", num_errors, comparisons);
    if (num_errors == 0 && comparisons > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : results
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic bus(input logic wr, input logic [7:0] idx, input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= 2'b10;
    haddr <= {22'h0, idx, 2'b00};
    hwrite <= wr;
    do @(posedge clk); while (hrdy !== 1'b1);
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge clk); while (hrdy !== 1'b1);
    q = hrdata;
  endtask : bus
  task automatic waitv(ref logic sig, input logic lvl);
    int n;
    n = 0;
    while (sig !== lvl && n < 4000) begin
      @(posedge clk);
      n++;
    end
    chk({31'h0, sig}, {31'h0, lvl});
  endtask : waitv
  task automatic rst(input logic [2:0] s);
    arst_n <= 1'b0;
    straps <= s;
    repeat (2) @(posedge clk);
    arst_n <= 1'b1;
    repeat (4) @(posedge clk);
  endtask : rst
  initial begin
    for (int i = 0; i < 4; i++) begin
      rst({1'b1, 2'(i)});
      bus(1'b0, IDX_ADVERT, 32'h0);
      chk(q, ADV[i]);
    end
    for (int i = 0; i < 4; i++) begin
      rst({1'b0, 2'(i)});
      chk({30'h0, spd, fdx}, 32'(i));
    end
    bus(1'b1, IDX_CONTROL, 32'h0100);
    repeat (4) @(posedge clk);
    chk({30'h0, spd, fdx}, 32'h1);
    bus(1'b0, IDX_STATUS, 32'h0);
    chk(q, 32'h0000_7849);
    bus(1'b0, 8'h03, 32'h0);
    chk(q, 32'h0);
    bus(1'b1, IDX_ADVERT, 32'h1E1);
    bus(1'b1, IDX_CONTROL, 32'h1000);
    waitv(quiet, 1'b1);
    pmode <= 4'b1101;
    waitv(lup, 1'b1);
    chk({30'h0, spd, fdx}, 32'h2);
    bus(1'b0, IDX_PARTNER, 32'h0);
    chk(q, 32'hE1);
    bus(1'b0, IDX_EXPAND, 32'h0);
    chk(q, 32'h3);
    bus(1'b0, IDX_LINKSTS, 32'h0);
    chk(q & 32'h17, 32'h11);
    bus(1'b1, IDX_CONTROL, 32'h1100);
    repeat (4) @(posedge clk);
    chk({30'h0, spd, fdx}, 32'h2);
    bus(1'b1, IDX_ADVERT, 32'h61);
    bus(1'b0, IDX_ADVERT, 32'h0);
    chk(q, 32'h61);
    pmode <= 4'b1010;
    bus(1'b1, IDX_CONTROL, 32'h1200);
    waitv(quiet, 1'b1);
    waitv(bsend, 1'b1);
    chk({16'h0, bword}, 32'h61);
    waitv(lup, 1'b1);
    chk({30'h0, spd, fdx}, 32'h1);
    pmode <= 4'b1000;
    waitv(lup, 1'b0);
    waitv(bsend, 1'b1);
    pmode <= 4'b0100;
    bus(1'b1, IDX_CONTROL, 32'h1200);
    waitv(quiet, 1'b1);
    waitv(lup, 1'b1);
    chk({30'h0, spd, fdx}, 32'h2);
    bus(1'b0, IDX_PARTNER, 32'h0);
    chk(q, 32'h81);
    bus(1'b0, IDX_EXPAND, 32'h0);
    chk(q & 32'h1, 32'h0);
    bus(1'b0, IDX_STATUS, 32'h0);
    chk(q & 32'h20, 32'h20);
    pmode <= 4'b0010;
    bus(1'b1, IDX_CONTROL, 32'h1200);
    waitv(lup, 1'b0);
    waitv(lup, 1'b1);
    chk({30'h0, spd, fdx}, 32'h0);
    bus(1'b0, IDX_PARTNER, 32'h0);
    chk(q, 32'h21);
    pmode <= 4'b0110;
    bus(1'b1, IDX_CONTROL, 32'h1200);
    waitv(quiet, 1'b1);
    q = 32'h0;
    for (int n = 0; n < 300 && q[4] !== 1'b1; n++) bus(1'b0, IDX_EXPAND, 32'h0);
    chk(q & 32'h10, 32'h10);
    chk({31'h0, hresp}, 32'h0);
    results();
  end
  initial begin
    repeat (40000) @(posedge clk);
    num_errors++;
    results();
  end
endmodule : test_autoneg_ctrl
